/* ddi_top.sv */
// Digital-input functions of a motor drive: status, filter, stop, purge, timer, ramps, duplex
`timescale 1ns/1ns

module ddi_top
  import ddi_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NUM_INPUTS-1:0] raw_inputs,
  input wire logic [7:0] filter_ms,
  input ddi_func_map_t func_map,
  output logic [NUM_INPUTS-1:0] input_status,
  input wire logic estop_self_reset,
  input wire logic estop_reset_req,
  output logic emergency_stop,
  input ddi_purge_src_t purge_source,
  output logic smoke_purge_active,
  output ddi_speed_src_t speed_source,
  output logic protections_enabled,
  input wire logic [2:0] timer_input_sel,
  input ddi_tmode_t timer_mode,
  input wire logic [12:0] timer_set_sec,
  input wire logic timer_nc,
  output logic timer_out,
  input ddi_ramp_t ramp_base,
  input wire logic ramp_load,
  input wire logic [1:0] ramp_load_index,
  input ddi_ramp_t ramp_load_value,
  input wire logic [15:0] change_freq,
  input wire logic [15:0] out_freq,
  output logic [1:0] ramp_pair,
  output ddi_ramp_t ramp_active,
  input ddi_duplex_t duplex_mode,
  input wire logic unit_two,
  input wire logic [7:0] alt_interval_hours,
  input wire logic run_minutes_wr,
  input wire logic [13:0] run_minutes_wdata,
  input wire logic self_faulted,
  input wire logic self_running,
  input wire logic stored_lead_cmd,
  input wire logic partner_faulted_pin,
  input wire logic link_unstable_pin,
  output logic lead_cmd,
  output logic lead_now,
  output logic [13:0] alternation_run_minutes
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic [MS_CNT_W-1:0] ms_cnt;
    logic ms_tick;
    logic [9:0] sec_cnt;
    logic sec_tick;
    logic [5:0] min_cnt;
    logic min_tick;
    logic estop;
    logic purge;
    ddi_speed_src_t src;
    logic [1:0] pair;
    ddi_ramp_t active;
    ddi_ramp_t r1;
    ddi_ramp_t r2;
    ddi_ramp_t r3;
    logic pf_sync1;
    logic pf_sync2;
    logic lu_sync1;
    logic lu_sync2;
    logic booted;
    logic lead_cmd;
    logic lead_now;
    logic hoa_d;
    logic alt_d;
    logic [13:0] run_min;
  } ddi_top_state_t;

  ddi_top_state_t st;
  ddi_top_state_t next_st;

  logic [NUM_INPUTS-1:0] filt;
  logic estop_in;
  logic smoke_in;
  logic ramp_lo;
  logic ramp_hi;
  logic lead_sw;
  logic hoa_not_auto;
  logic alt_btn;
  logic timer_trig;
  logic [1:0] ramp_code;
  logic [7:0] hours;
  logic [13:0] interval_min;
  logic actual_lead;

  // Index decode shared by every function assignment
  function automatic logic pick(input logic [NUM_INPUTS-1:0] vec, input logic [3:0] idx);
    logic r;
    r = 1'b0;
    if (idx < 4'(NUM_INPUTS)) begin
      r = vec[idx];
    end
    return r;
  endfunction : pick

  // ***********************************************************
  // Submodules
  // ***********************************************************
  ddi_filter u_filter (
    .clk(clk),
    .nrst(nrst),
    .ms_tick(st.ms_tick),
    .filter_ms(filter_ms),
    .raw(raw_inputs),
    .filt(filt)
  );

  ddi_aux_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .sec_tick(st.sec_tick),
    .trig(timer_trig),
    .mode(timer_mode),
    .set_sec(timer_set_sec),
    .timer_out(timer_out)
  );

  // ***********************************************************
  // Input decode
  // ***********************************************************
  assign estop_in = pick(filt, func_map.estop);
  assign smoke_in = pick(filt, func_map.smoke);
  assign ramp_lo = pick(filt, func_map.ramp_low);
  assign ramp_hi = pick(filt, func_map.ramp_high);
  assign lead_sw = pick(filt, func_map.lead_switch);
  assign hoa_not_auto = pick(filt, func_map.hand_off_auto_switch);
  assign alt_btn = pick(filt, func_map.alt_button);
  // Select 7 is decoded as no input and never triggers, though input 7 exists
  assign timer_trig = (timer_input_sel != 3'h7) &&
                      (pick(filt, {1'b0, timer_input_sel}) ^ timer_nc);
  assign ramp_code = {ramp_hi, ramp_lo};
  assign hours = (alt_interval_hours > ALT_HOURS_MAX) ? ALT_HOURS_MAX : alt_interval_hours;
  assign interval_min = 14'(hours) * MIN_PER_HOUR;

  // Actual role; commanded role stays in st.lead_cmd
  always_comb begin
    actual_lead = st.lead_cmd;
    if (duplex_mode == dup_none) begin
      actual_lead = 1'b1;
    end else if (st.lu_sync2) begin
      actual_lead = !unit_two;
    end else if (self_faulted || hoa_not_auto) begin
      actual_lead = 1'b0;
    end else if (st.pf_sync2) begin
      actual_lead = 1'b1;
    end
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    next_st = st;

    // Tick dividers: ms from the clock, seconds from ms, minutes from seconds
    next_st.ms_tick = 1'b0;
    next_st.sec_tick = 1'b0;
    next_st.min_tick = 1'b0;
    if (st.ms_cnt >= MS_CNT_W'(MS_CYCLES - 1)) begin
      next_st.ms_cnt = '0;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.ms_cnt = st.ms_cnt + MS_CNT_W'(1);
    end
    if (st.ms_tick) begin
      if (st.sec_cnt >= (MS_PER_SEC - 10'h001)) begin
        next_st.sec_cnt = 10'h000;
        next_st.sec_tick = 1'b1;
      end else begin
        next_st.sec_cnt = st.sec_cnt + 10'h001;
      end
    end
    if (st.sec_tick) begin
      if (st.min_cnt >= (SEC_PER_MIN - 6'h01)) begin
        next_st.min_cnt = 6'h00;
        next_st.min_tick = 1'b1;
      end else begin
        next_st.min_cnt = st.min_cnt + 6'h01;
      end
    end

    // Emergency stop; an activation in the reset cycle wins
    if (estop_in) begin
      next_st.estop = 1'b1;
    end else if (estop_self_reset) begin
      next_st.estop = 1'b0;
    end else if (estop_reset_req) begin
      next_st.estop = 1'b0;
    end

    // Smoke purge speed source
    next_st.purge = smoke_in;
    if (smoke_in) begin
      case (purge_source)
        purge_max: next_st.src = src_max;
        purge_preset: next_st.src = src_preset;
        purge_pid: next_st.src = src_pid;
        default: next_st.src = src_max;
      endcase
    end else begin
      next_st.src = src_normal;
    end

    // Ramp pair times, reloadable from outside
    if (ramp_load) begin
      case (ramp_load_index)
        2'h1: next_st.r1 = ramp_load_value;
        2'h2: next_st.r2 = ramp_load_value;
        2'h3: next_st.r3 = ramp_load_value;
        default: next_st.r1 = st.r1;
      endcase
    end
    next_st.pair = ramp_code;
    if ((ramp_code == 2'h1) && (change_freq != 16'h0000) && (out_freq <= change_freq)) begin
      next_st.pair = 2'h0;
    end
    case (next_st.pair)
      2'h1: next_st.active = st.r1;
      2'h2: next_st.active = st.r2;
      2'h3: next_st.active = st.r3;
      default: next_st.active = ramp_base;
    endcase

    // Pin synchronisers from the partner drive
    next_st.pf_sync1 = partner_faulted_pin;
    next_st.pf_sync2 = st.pf_sync1;
    next_st.lu_sync1 = link_unstable_pin;
    next_st.lu_sync2 = st.lu_sync1;

    // Commanded role
    next_st.hoa_d = hoa_not_auto;
    next_st.alt_d = alt_btn;
    next_st.booted = 1'b1;
    if (!st.booted) begin
      // Only a true power-up reaches here; low-voltage recovery does not reset this block
      next_st.lead_cmd = stored_lead_cmd ^ (duplex_mode == dup_powerup);
    end else begin
      case (duplex_mode)
        dup_lead_sw: begin
          next_st.lead_cmd = lead_sw;
        end
        dup_timer, dup_powerup: begin
          if (alt_btn && !st.alt_d) begin
            next_st.lead_cmd = !st.lead_cmd;
          end else if ((duplex_mode == dup_timer) && (interval_min != 14'h0000) &&
                       (st.run_min >= interval_min)) begin
            next_st.lead_cmd = !st.lead_cmd;
          end
        end
        default: next_st.lead_cmd = st.lead_cmd;
      endcase
      if (hoa_not_auto && !st.hoa_d && st.lead_now) begin
        next_st.lead_cmd = 1'b0;
      end
    end
    next_st.lead_now = actual_lead;

    // Lead run-time counter in minutes
    if (st.lead_now && !actual_lead) begin
      next_st.run_min = 14'h0000;
    end else if (run_minutes_wr) begin
      next_st.run_min = run_minutes_wdata;
    end else if ((duplex_mode == dup_timer) && (interval_min != 14'h0000) &&
                 (st.run_min >= interval_min)) begin
      next_st.run_min = 14'h0000;
    end else if (st.min_tick && st.lead_now && self_running && (st.run_min != 14'h3fff)) begin
      next_st.run_min = st.run_min + 14'h0001;
    end
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.src <= src_normal;
      st.r1 <= '{acc: RAMP1_DEFAULT, dec: RAMP1_DEFAULT};
      st.r2 <= '{acc: RAMP2_DEFAULT, dec: RAMP2_DEFAULT};
      st.r3 <= '{acc: RAMP3_DEFAULT, dec: RAMP3_DEFAULT};
    end else begin
      st <= next_st;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign input_status = filt;
  assign emergency_stop = st.estop;
  assign smoke_purge_active = st.purge;
  assign speed_source = st.src;
  assign protections_enabled = !st.purge;
  assign ramp_pair = st.pair;
  assign ramp_active = st.active;
  assign lead_cmd = st.lead_cmd;
  assign lead_now = st.lead_now;
  assign alternation_run_minutes = st.run_min;

endmodule : ddi_top

/* ddi_pkg.sv */
// Constants, enumerations and carriers shared by the digital-input function logic
package ddi_pkg;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS_NS = 1_000_000;
  localparam int MS_CYCLES_DEFAULT = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;
  localparam logic [9:0] MS_PER_SEC = 10'h3e8;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;
  localparam logic [13:0] MIN_PER_HOUR = 14'h003c;

  // ***********************************************************
  // Inputs and defaults
  // ***********************************************************
  localparam int NUM_INPUTS = 11;
  localparam logic [7:0] FILTER_MS_DEFAULT = 8'h0f;
  localparam logic [7:0] ALT_HOURS_MAX = 8'ha8;
  localparam logic [7:0] ALT_HOURS_DEFAULT = 8'ha8;
  localparam logic [12:0] TIMER_SEC_DEFAULT = 13'h001e;
  localparam logic [12:0] TIMER_SEC_MAX = 13'h1770;
  localparam logic [15:0] RAMP1_DEFAULT = 16'h00c8;
  localparam logic [15:0] RAMP2_DEFAULT = 16'h012c;
  localparam logic [15:0] RAMP3_DEFAULT = 16'h0190;
  localparam logic [15:0] CHANGE_FREQ_DEFAULT = 16'h0000;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {tm_on_delay, tm_off_delay, tm_one_pulse, tm_symm_pulse} ddi_tmode_t;
  typedef enum logic [1:0] {purge_max, purge_preset, purge_pid} ddi_purge_src_t;
  typedef enum logic [1:0] {src_normal, src_max, src_preset, src_pid} ddi_speed_src_t;
  typedef enum logic [1:0] {dup_none, dup_lead_sw, dup_timer, dup_powerup} ddi_duplex_t;

  // Acceleration and deceleration time, tenths of a second
  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] dec;
  } ddi_ramp_t;

  // Input index (0..10) assigned to each function
  typedef struct packed {
    logic [3:0] estop;
    logic [3:0] smoke;
    logic [3:0] ramp_low;
    logic [3:0] ramp_high;
    logic [3:0] lead_switch;
    logic [3:0] hand_off_auto_switch;
    logic [3:0] alt_button;
  } ddi_func_map_t;

endpackage : ddi_pkg

/* ddi_filter.sv */
// Two-flop synchroniser and millisecond debounce filter for the digital inputs
`timescale 1ns/1ns
module ddi_filter
  import ddi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ms_tick,
  input wire logic [7:0] filter_ms,
  input wire logic [NUM_INPUTS-1:0] raw,
  output logic [NUM_INPUTS-1:0] filt
);

  typedef struct packed {
    logic [NUM_INPUTS-1:0] sync1;
    logic [NUM_INPUTS-1:0] sync2;
    logic [NUM_INPUTS-1:0] filt;
    logic [NUM_INPUTS-1:0][7:0] cnt;
  } ddi_filter_state_t;

  ddi_filter_state_t st;
  ddi_filter_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (st.sync2[i] == st.filt[i]) begin
        next_st.cnt[i] = 8'h00;
      end else if (ms_tick) begin
        if (st.cnt[i] >= filter_ms) begin
          next_st.filt[i] = st.sync2[i];
          next_st.cnt[i] = 8'h00;
        end else begin
          next_st.cnt[i] = st.cnt[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filt = st.filt;

endmodule : ddi_filter

/* ddi_aux_timer.sv */
// Auxiliary in-out timer: on-delay, off-delay, single pulse and symmetric pulses
`timescale 1ns/1ns
module ddi_aux_timer
  import ddi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sec_tick,
  input wire logic trig,
  input ddi_tmode_t mode,
  input wire logic [12:0] set_sec,
  output logic timer_out
);

  typedef struct packed {
    logic out;
    logic trig_d;
    logic [12:0] cnt;
  } ddi_timer_state_t;

  ddi_timer_state_t st;
  ddi_timer_state_t next_st;
  logic [12:0] limit;
  logic done;

  assign limit = (set_sec > TIMER_SEC_MAX) ? TIMER_SEC_MAX : set_sec;
  assign done = (st.cnt >= limit);

  always_comb begin
    next_st = st;
    next_st.trig_d = trig;
    case (mode)
      tm_on_delay: begin
        if (!trig) begin
          next_st.out = 1'b0;
          next_st.cnt = 13'h0000;
        end else if (done) begin
          next_st.out = 1'b1;
        end else if (sec_tick) begin
          next_st.cnt = st.cnt + 13'h0001;
        end
      end
      tm_off_delay: begin
        if (trig) begin
          next_st.out = 1'b1;
          next_st.cnt = 13'h0000;
        end else if (st.out && done) begin
          next_st.out = 1'b0;
        end else if (st.out && sec_tick) begin
          next_st.cnt = st.cnt + 13'h0001;
        end
      end
      tm_one_pulse: begin
        if (!st.out && trig && !st.trig_d) begin
          next_st.out = 1'b1;
          next_st.cnt = 13'h0000;
        end else if (st.out && done) begin
          next_st.out = 1'b0;
        end else if (st.out && sec_tick) begin
          next_st.cnt = st.cnt + 13'h0001;
        end
      end
      tm_symm_pulse: begin
        if (!trig) begin
          next_st.out = 1'b0;
          next_st.cnt = 13'h0000;
        end else if (!st.trig_d) begin
          next_st.out = 1'b1;
          next_st.cnt = 13'h0000;
        end else if (done) begin
          next_st.out = !st.out;
          next_st.cnt = 13'h0000;
        end else if (sec_tick) begin
          next_st.cnt = st.cnt + 13'h0001;
        end
      end
      default: begin
        next_st.out = 1'b0;
        next_st.cnt = 13'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer_out = st.out;

endmodule : ddi_aux_timer

/* ddi_top_sva.sv */
// Concurrent checks on the ports of the digital-input function block
`timescale 1ns/1ns
module ddi_top_sva
  import ddi_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input ddi_func_map_t func_map,
  input wire logic [NUM_INPUTS-1:0] input_status,
  input wire logic estop_self_reset,
  input wire logic estop_reset_req,
  input wire logic emergency_stop,
  input ddi_purge_src_t purge_source,
  input wire logic smoke_purge_active,
  input ddi_speed_src_t speed_source,
  input wire logic protections_enabled,
  input wire logic [15:0] change_freq,
  input wire logic [15:0] out_freq,
  input wire logic [1:0] ramp_pair,
  input ddi_ramp_t ramp_active,
  input ddi_ramp_t ramp_base,
  input ddi_duplex_t duplex_mode,
  input wire logic self_faulted,
  input wire logic link_unstable_pin,
  input wire logic lead_now,
  input wire logic [13:0] alternation_run_minutes
);
  // ***************************************************
  // Helpers
  // ***************************************************
  logic [2:0] quiet;
  logic [1:0] sel;
  logic estop_in;
  assign estop_in = input_status[func_map.estop];
  assign sel = {input_status[func_map.ramp_high], input_status[func_map.ramp_low]};

  // Cycles the unstable pin has been low, so its synchroniser has settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet <= 3'h0;
    end else if (link_unstable_pin) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end

  function automatic ddi_speed_src_t purge_map(ddi_purge_src_t p);
    return p == purge_max ? src_max : (p == purge_preset ? src_preset : src_pid);
  endfunction : purge_map

  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence estop_on;
    $rose(estop_in);
  endsequence
  sequence estop_off;
    $fell(estop_in) && estop_self_reset;
  endsequence

  chk_estop_set: assert property (estop_on |-> ##[1:2] emergency_stop)
    else $error("emergency stop not entered");
  chk_estop_latch: assert property (emergency_stop && !estop_self_reset && !estop_reset_req
    && !$past(estop_reset_req) |=> emergency_stop)
    else $error("emergency stop dropped without reset");
  chk_estop_auto: assert property (estop_off |-> ##[1:2] !emergency_stop)
    else $error("emergency stop not self cleared");
  chk_protect_tie: assert property ($past(input_status[func_map.smoke])
    != protections_enabled)
    else $error("protections wrong for purge state");
  chk_purge_speed: assert property (smoke_purge_active && $past(smoke_purge_active)
    |-> speed_source == purge_map($past(purge_source)))
    else $error("purge speed source wrong");
  chk_normal_speed: assert property (!smoke_purge_active |-> speed_source == src_normal)
    else $error("speed source not normal");
  chk_ramp_code: assert property (change_freq == 16'h0000 && $past(change_freq) == 16'h0000
    && sel == $past(sel) && sel == $past(sel, 2) |-> ramp_pair == sel)
    else $error("ramp pair not from select code");
  chk_ramp_gate: assert property (ramp_pair == 2'h1 |-> $past(change_freq) == 16'h0000
    || $past(out_freq) > $past(change_freq))
    else $error("pair one used below change frequency");
  chk_ramp_base: assert property ($past(nrst) && ramp_pair == 2'h0 && $stable(ramp_base)
    |-> ramp_active == ramp_base)
    else $error("base ramp pair not applied");
  chk_dup_none: assert property ($past(nrst, 2) && $past(duplex_mode) == dup_none
    && $past(duplex_mode, 2) == dup_none |-> lead_now)
    else $error("lead status wrong with duplex off");
  chk_lag_fault: assert property (quiet == 3'h7 && self_faulted && $past(self_faulted)
    && duplex_mode != dup_none && $past(duplex_mode) != dup_none |=> !lead_now)
    else $error("faulted unit still leads");
  chk_run_clear: assert property ($fell(lead_now) |=> alternation_run_minutes == 14'h0000)
    else $error("run minutes not cleared on lag");
endmodule : ddi_top_sva

bind ddi_top ddi_top_sva #(.MS_CYCLES(MS_CYCLES)) sva_u (.clk, .nrst, .func_map,
  .input_status, .estop_self_reset, .estop_reset_req, .emergency_stop, .purge_source,
  .smoke_purge_active, .speed_source, .protections_enabled, .change_freq, .out_freq,
  .ramp_pair, .ramp_active, .ramp_base, .duplex_mode, .self_faulted, .link_unstable_pin,
  .lead_now, .alternation_run_minutes);

/* ddi_field.sv */
// Field contacts with bounce and the status pins of the paired drive
`timescale 1ns/1ns
module ddi_field
  import ddi_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_INPUTS-1:0] contacts,
  input wire logic partner_fault_req,
  input wire logic unstable_req,
  output logic [NUM_INPUTS-1:0] raw_inputs,
  output logic partner_faulted_pin,
  output logic link_unstable_pin
);
  logic [NUM_INPUTS-1:0] last = '0;
  logic [NUM_INPUTS-1:0] diff = '0;
  logic [2:0] bounce = 3'h0;
  initial begin
    raw_inputs = '0;
    partner_faulted_pin = 1'b0;
    link_unstable_pin = 1'b0;
  end
  // A changed contact chatters between old and new level before it settles
  always @(posedge clk) begin
    if (contacts != last) begin
      last <= contacts;
      diff <= contacts ^ last;
      bounce <= 3'h5;
    end else if (bounce != 3'h0) begin
      bounce <= bounce - 3'h1;
    end
    raw_inputs <= (bounce != 3'h0 && bounce[0]) ? last ^ diff : last;
    partner_faulted_pin <= partner_fault_req;
    link_unstable_pin <= unstable_req;
  end
endmodule : ddi_field

/* ddi_top_bench.sv */
// Self-checking bench for the digital-input function block
`timescale 1ns/1ns
module ddi_top_bench;
  import ddi_pkg::*;
  logic clk, nrst = 1'b0, pf_req = 1'b0, un_req = 1'b0, ramp_load = 1'b0, timer_nc = 1'b0;
  logic [NUM_INPUTS-1:0] contacts = '0, raw_inputs, input_status;
  logic partner_faulted_pin, link_unstable_pin, emergency_stop, smoke_purge_active;
  logic protections_enabled, timer_out, lead_cmd, lead_now;
  logic estop_self_reset = 1'b1, estop_reset_req = 1'b0, unit_two = 1'b0, run_minutes_wr = 1'b0;
  logic self_faulted = 1'b0, self_running = 1'b0, stored_lead_cmd = 1'b1;
  ddi_func_map_t func_map = {4'h8, 4'h9, 4'h0, 4'h1, 4'h4, 4'h5, 4'h3};
  ddi_purge_src_t purge_source = purge_max;
  ddi_speed_src_t speed_source;
  logic [2:0] timer_input_sel = 3'h6;
  ddi_tmode_t timer_mode = tm_on_delay;
  logic [12:0] timer_set_sec = 13'h0002;
  ddi_ramp_t ramp_base = {16'h0032, 16'h0028}, ramp_load_value = {16'h0055, 16'h0066};
  ddi_ramp_t ramp_active;
  logic [1:0] ramp_load_index = 2'h2, ramp_pair;
  logic [15:0] change_freq = 16'h0000, out_freq = 16'h0000, rt;
  ddi_duplex_t duplex_mode = dup_none;
  logic [7:0] filter_ms = FILTER_MS_DEFAULT, alt_interval_hours = ALT_HOURS_DEFAULT;
  logic [13:0] run_minutes_wdata = 14'h0000, alternation_run_minutes;
  int failures = 0, total_checks = 0;

  ddi_field field_u (.clk, .contacts, .partner_fault_req(pf_req), .unstable_req(un_req),
    .raw_inputs, .partner_faulted_pin, .link_unstable_pin);
  ddi_top #(.MS_CYCLES(2)) dut_u (.clk, .nrst, .raw_inputs, .filter_ms, .func_map,
    .input_status, .estop_self_reset, .estop_reset_req, .emergency_stop, .purge_source,
    .smoke_purge_active, .speed_source, .protections_enabled, .timer_input_sel, .timer_mode,
    .timer_set_sec, .timer_nc, .timer_out, .ramp_base, .ramp_load, .ramp_load_index,
    .ramp_load_value, .change_freq, .out_freq, .ramp_pair, .ramp_active, .duplex_mode,
    .unit_two, .alt_interval_hours, .run_minutes_wr, .run_minutes_wdata, .self_faulted,
    .self_running, .stored_lead_cmd, .partner_faulted_pin, .link_unstable_pin, .lead_cmd,
    .lead_now, .alternation_run_minutes);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ***************************************************
  // Access tasks
  // ***************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : w
  // One ms tick is two clocks, so 45 clocks clears bounce, sync and 15 ms filter
  task automatic put(input int i, input logic v);
    @(posedge clk);
    contacts[i] <= v;
    w(45);
  endtask : put
  task automatic do_reset(input logic stored);
    @(posedge clk);
    nrst <= 1'b0;
    stored_lead_cmd <= stored;
    w(2);
    @(posedge clk);
    nrst <= 1'b1;
    w(3);
  endtask : do_reset
  task automatic print_verdict;
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end

  // ***************************************************
  // Tests
  // ***************************************************
  initial begin
    do_reset(1'b1);
    check("speed", speed_source, src_normal);
    for (int i = 0; i < NUM_INPUTS; i++) begin
      put(i, 1'b1);
      check("status", input_status, 32'h1 << i);
      put(i, 1'b0);
    end
    @(posedge clk);
    contacts[7] <= 1'b1;
    w(20);
    check("early", input_status[7], 1'b0);
    put(7, 1'b0);
    check("glitch", input_status[7], 1'b0);
    @(posedge clk);
    estop_self_reset <= 1'b0;
    put(8, 1'b1);
    put(8, 1'b0);
    check("latch", emergency_stop, 1'b1);
    @(posedge clk);
    estop_reset_req <= 1'b1;
    @(posedge clk);
    estop_reset_req <= 1'b0;
    w(2);
    check("unlatch", emergency_stop, 1'b0);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      purge_source <= ddi_purge_src_t'(s);
      put(9, 1'b1);
      check("purge", speed_source, s == 0 ? src_max : s == 1 ? src_preset : src_pid);
      check("prot off", protections_enabled, 1'b0);
      put(9, 1'b0);
      check("prot on", protections_enabled, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      put(0, c[0]);
      put(1, c[1]);
      rt = c == 1 ? RAMP1_DEFAULT : c == 2 ? RAMP2_DEFAULT : RAMP3_DEFAULT;
      check("pair", ramp_pair, c);
      check("ramp", ramp_active, c == 0 ? 32'(ramp_base) : {rt, rt});
    end
    @(posedge clk);
    ramp_load <= 1'b1;
    @(posedge clk);
    ramp_load <= 1'b0;
    put(0, 1'b0);
    check("loaded", ramp_active, ramp_load_value);
    put(1, 1'b0);
    put(0, 1'b1);
    @(posedge clk);
    change_freq <= 16'h03e8;
    out_freq <= 16'h01f4;
    w(3);
    check("gated", ramp_pair, 2'h0);
    @(posedge clk);
    out_freq <= 16'h05dc;
    w(3);
    check("above", ramp_pair, 2'h1);
    put(6, 1'b1);
    w(1500);
    check("on early", timer_out, 1'b0);
    w(3000);
    check("on late", timer_out, 1'b1);
    @(posedge clk);
    timer_nc <= 1'b1;
    timer_mode <= tm_one_pulse;
    w(45);
    check("nc idle", timer_out, 1'b0);
    put(6, 1'b0);
    put(6, 1'b1);
    w(1500);
    check("pulse", timer_out, 1'b1);
    w(3000);
    check("one only", timer_out, 1'b0);
    @(posedge clk);
    timer_mode <= tm_off_delay;
    timer_nc <= 1'b0;
    put(6, 1'b0);
    check("off hold", timer_out, 1'b1);
    w(4500);
    check("off end", timer_out, 1'b0);
    @(posedge clk);
    timer_mode <= tm_symm_pulse;
    put(6, 1'b1);
    check("symm on", timer_out, 1'b1);
    w(4500);
    check("symm low", timer_out, 1'b0);
    w(4000);
    check("symm high", timer_out, 1'b1);
    put(6, 1'b0);
    check("symm off", timer_out, 1'b0);
    @(posedge clk);
    duplex_mode <= dup_lead_sw;
    put(4, 1'b1);
    check("lead", lead_now, 1'b1);
    @(posedge clk);
    self_faulted <= 1'b1;
    w(3);
    check("fault now", lead_now, 1'b0);
    check("fault cmd", lead_cmd, 1'b1);
    @(posedge clk);
    self_faulted <= 1'b0;
    w(3);
    check("back", lead_now, 1'b1);
    put(4, 1'b0);
    @(posedge clk);
    pf_req <= 1'b1;
    w(6);
    check("partner", lead_now, 1'b1);
    @(posedge clk);
    pf_req <= 1'b0;
    un_req <= 1'b1;
    unit_two <= 1'b1;
    w(6);
    check("unit two", lead_now, 1'b0);
    @(posedge clk);
    unit_two <= 1'b0;
    w(3);
    check("unit one", lead_now, 1'b1);
    @(posedge clk);
    un_req <= 1'b0;
    put(4, 1'b1);
    @(posedge clk);
    duplex_mode <= dup_timer;
    self_running <= 1'b1;
    run_minutes_wr <= 1'b1;
    run_minutes_wdata <= 14'h0025;
    @(posedge clk);
    run_minutes_wr <= 1'b0;
    w(2);
    check("minutes", alternation_run_minutes, 14'h0025);
    put(5, 1'b1);
    check("hoa lag", lead_now, 1'b0);
    check("cleared", alternation_run_minutes, 14'h0000);
    put(5, 1'b0);
    check("stay lag", lead_now, 1'b0);
    put(3, 1'b1);
    check("alt", lead_cmd, 1'b1);
    @(posedge clk);
    run_minutes_wr <= 1'b1;
    run_minutes_wdata <= 14'h2760;
    @(posedge clk);
    run_minutes_wr <= 1'b0;
    w(2);
    check("timed alt", lead_cmd, 1'b0);
    @(posedge clk);
    duplex_mode <= dup_powerup;
    do_reset(1'b0);
    check("power up", lead_cmd, 1'b1);
    do_reset(1'b1);
    check("power up 2", lead_cmd, 1'b0);
    print_verdict();
  end
endmodule : ddi_top_bench
